// *** verilog/sct_pkg.sv ***
// Purpose: Shared constants and types of the 16-bit capture timer.
// Assumes: Byte-wide register port with 8-bit addresses.
// Notes: Channel count and field layouts are fixed here.
package sct_pkg;

  localparam int unsigned NUM_CHAN = 3;

  // Register addresses.
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hE2;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hE3;
  localparam logic [7:0] ADDR_CONTROL = 8'hE4;
  localparam logic [7:0] ADDR_CHAN_CTL0 = 8'hE5;
  localparam logic [7:0] ADDR_CHAN_VAL0 = 8'hDA;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hD8;
  localparam logic [7:0] ADDR_CLOCK_CTL = 8'hC6;
  localparam logic [7:0] ADDR_RADIO_EN = 8'h91;

  // Control and status field positions.
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned CTL_DIV_LSB = 2;
  localparam int unsigned CTL_OVF_BIT = 4;
  localparam int unsigned CTL_CHF_LSB = 5;
  localparam int unsigned OVF_MASK_BIT = 6;
  localparam int unsigned TICK_DIV_LSB = 3;

  // Reset and terminal values.
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] TICK_DIV_RESET = 3'h0;

  // Counting modes.
  localparam logic [1:0] MODE_HALT = 2'h0;
  localparam logic [1:0] MODE_FREE = 2'h1;
  localparam logic [1:0] MODE_MODULO = 2'h2;
  localparam logic [1:0] MODE_UPDOWN = 2'h3;

  // Prescale codes and their tick masks: divide by 1, 8, 32 or 128.
  localparam logic [1:0] DIV_1 = 2'h0;
  localparam logic [1:0] DIV_8 = 2'h1;
  localparam logic [1:0] DIV_32 = 2'h2;
  localparam logic [1:0] DIV_128 = 2'h3;
  localparam logic [6:0] MASK_DIV_1 = 7'h00;
  localparam logic [6:0] MASK_DIV_8 = 7'h07;
  localparam logic [6:0] MASK_DIV_32 = 7'h1F;
  localparam logic [6:0] MASK_DIV_128 = 7'h7F;

  // Capture edge codes.
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

  typedef struct packed {
    logic capture_source_select;
    logic chan_irq_mask;
    logic [2:0] compare_mode;
    logic compare;
    logic [1:0] capture_edge;
  } sct_chan_ctl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sct_bus_req_t;

  typedef enum logic [1:0] {
    SCT_DIR_UP = 2'b01,
    SCT_DIR_DOWN = 2'b10
  } sct_dir_t;

endpackage

// *** verilog/sct_timer.sv ***
// Purpose: 16-bit timer with three capture channels and a byte register port.
// Assumes: Channel pins are asynchronous; radio events share this clock.
// Notes: Output compare is stored in the channel control; it only blocks capture and drives no output.
`timescale 1ns/1ps

module sct_timer #(
  parameter int unsigned RADIO_W = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic ce,
  input wire sct_pkg::sct_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic [sct_pkg::NUM_CHAN-1:0] chan_pin,
  input wire logic [RADIO_W-1:0] radio_irq_event,
  output logic irq
);

  localparam int unsigned NC = sct_pkg::NUM_CHAN;

  logic [1:0] rst_sync;
  logic rst_n;
  logic [15:0] count;
  sct_pkg::sct_dir_t dir;
  logic [7:0] count_high_latch;
  logic [1:0] mode;
  logic [1:0] prescale;
  logic overflow_flag;
  logic [NC-1:0] chan_flag;
  logic overflow_mask;
  logic [2:0] global_tick_divider;
  logic [RADIO_W-1:0] radio_irq_enables;
  sct_pkg::sct_chan_ctl_t chan_control [NC];
  logic [15:0] chan_value [NC];
  logic [NC-1:0] pin_s1;
  logic [NC-1:0] pin_s2;
  logic [NC-1:0] pin_prev;
  logic [6:0] gdiv_count;
  logic [6:0] pre_count;
  logic global_tick;
  logic step;
  logic wr_low;
  logic rd_low;
  logic radio_hit;
  logic [NC-1:0] cap_ev;
  logic [15:0] next_count;
  sct_pkg::sct_dir_t next_dir;
  logic wrap_ovf;
  logic irq_any;

  function automatic logic [6:0] div_mask(input logic [1:0] code);
    logic [6:0] m;
    m = sct_pkg::MASK_DIV_1;
    unique case (code)
      sct_pkg::DIV_1: m = sct_pkg::MASK_DIV_1;
      sct_pkg::DIV_8: m = sct_pkg::MASK_DIV_8;
      sct_pkg::DIV_32: m = sct_pkg::MASK_DIV_32;
      sct_pkg::DIV_128: m = sct_pkg::MASK_DIV_128;
    endcase
    return m;
  endfunction

  function automatic logic edge_hit(input logic [1:0] sel, input logic now, input logic prev);
    logic h;
    h = 1'b0;
    unique case (sel)
      sct_pkg::EDGE_NONE: h = 1'b0;
      sct_pkg::EDGE_RISE: h = now & ~prev;
      sct_pkg::EDGE_FALL: h = ~now & prev;
      sct_pkg::EDGE_ANY: h = now ^ prev;
    endcase
    return h;
  endfunction

  function automatic logic is_addr(input sct_pkg::sct_bus_req_t r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  // Reset release is synchronised; assertion stays asynchronous.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign wr_low = ce & bus_req.wr & is_addr(bus_req, sct_pkg::ADDR_COUNT_LOW);
  assign rd_low = ce & bus_req.rd & is_addr(bus_req, sct_pkg::ADDR_COUNT_LOW);

  // Global tick divider followed by the local prescaler.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      gdiv_count <= 7'h00;
      pre_count <= 7'h00;
    end else if (ce) begin
      gdiv_count <= gdiv_count + 7'h01;
      if (global_tick) begin
        pre_count <= pre_count + 7'h01;
      end
    end
  end

  always_comb begin
    logic [6:0] gm;
    gm = 7'h00;
    for (int k = 0; k < 7; k++) begin
      gm[k] = (k < int'(global_tick_divider));
    end
    global_tick = (gdiv_count & gm) == gm;
    step = ce & global_tick & ((pre_count & div_mask(prescale)) == div_mask(prescale));
  end

  // Counter next value for each counting mode.
  always_comb begin
    next_count = count;
    next_dir = dir;
    wrap_ovf = 1'b0;
    if (step) begin
      unique case (mode)
        sct_pkg::MODE_HALT: next_count = count;
        sct_pkg::MODE_FREE: begin
          next_count = count + 16'h0001;
          wrap_ovf = (count == sct_pkg::COUNT_TOP);
        end
        sct_pkg::MODE_MODULO: begin
          if (count == chan_value[0]) begin
            next_count = sct_pkg::COUNT_RESET;
            wrap_ovf = 1'b1;
          end else begin
            next_count = count + 16'h0001;
          end
        end
        sct_pkg::MODE_UPDOWN: begin
          if (dir == sct_pkg::SCT_DIR_UP) begin
            if (count >= chan_value[0] && count != sct_pkg::COUNT_RESET) begin
              next_dir = sct_pkg::SCT_DIR_DOWN;
              next_count = count - 16'h0001;
            end else if (count != chan_value[0]) begin
              next_count = count + 16'h0001;
            end
          end else begin
            if (count == sct_pkg::COUNT_RESET) begin
              next_dir = sct_pkg::SCT_DIR_UP;
              if (chan_value[0] != sct_pkg::COUNT_RESET) begin
                next_count = count + 16'h0001;
              end
            end else begin
              next_count = count - 16'h0001;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= sct_pkg::COUNT_RESET;
      dir <= sct_pkg::SCT_DIR_UP;
    end else if (wr_low) begin
      count <= sct_pkg::COUNT_RESET;
      dir <= sct_pkg::SCT_DIR_UP;
    end else if (ce) begin
      count <= next_count;
      dir <= next_dir;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_high_latch <= sct_pkg::BYTE_RESET;
    end else if (rd_low) begin
      count_high_latch <= count[15:8];
    end
  end

  // Capture pins: two synchroniser stages, then an edge history stage.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_prev <= '0;
    end else if (ce) begin
      pin_s1 <= chan_pin;
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  assign radio_hit = |(radio_irq_event & radio_irq_enables);

  generate
    for (genvar i = 0; i < NC; i++) begin : g_chan
      localparam logic [7:0] CTL_ADDR = sct_pkg::ADDR_CHAN_CTL0 + 8'(i);
      localparam logic [7:0] LOW_ADDR = sct_pkg::ADDR_CHAN_VAL0 + 8'(2 * i);
      localparam logic [7:0] HIGH_ADDR = sct_pkg::ADDR_CHAN_VAL0 + 8'(2 * i + 1);

      // A channel captures only while the timer runs and it is not comparing.
      always_comb begin
        cap_ev[i] = 1'b0;
        if (mode != sct_pkg::MODE_HALT && !chan_control[i].compare) begin
          if (chan_control[i].capture_source_select) begin
            cap_ev[i] = ce & radio_hit;
          end else begin
            cap_ev[i] = ce & edge_hit(chan_control[i].capture_edge, pin_s2[i], pin_prev[i]);
          end
        end
      end

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          chan_control[i] <= '0;
        end else if (ce && bus_req.wr && is_addr(bus_req, CTL_ADDR)) begin
          chan_control[i] <= bus_req.wdata;
        end
      end

      // A capture beats a software write to the same value register.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          chan_value[i] <= sct_pkg::COUNT_RESET;
        end else if (cap_ev[i]) begin
          chan_value[i] <= count;
        end else if (ce && bus_req.wr && is_addr(bus_req, LOW_ADDR)) begin
          chan_value[i][7:0] <= bus_req.wdata;
        end else if (ce && bus_req.wr && is_addr(bus_req, HIGH_ADDR)) begin
          chan_value[i][15:8] <= bus_req.wdata;
        end
      end

      // Hardware set wins over a software clear in the same cycle.
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          chan_flag[i] <= 1'b0;
        end else if (cap_ev[i]) begin
          chan_flag[i] <= 1'b1;
        end else if (ce && bus_req.wr && is_addr(bus_req, sct_pkg::ADDR_CONTROL)) begin
          chan_flag[i] <= chan_flag[i] & bus_req.wdata[sct_pkg::CTL_CHF_LSB + i];
        end
      end

      AST_CAPTURE_VALUE: assert property (@(posedge clock) disable iff (!rst_n)
        cap_ev[i] |=> chan_value[i] == $past(count) && chan_flag[i])
        else $error("capture did not store the counter");
    end
  endgenerate

  // Control and configuration registers written by software.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= sct_pkg::MODE_HALT;
      prescale <= sct_pkg::DIV_1;
      overflow_mask <= 1'b0;
      global_tick_divider <= sct_pkg::TICK_DIV_RESET;
      radio_irq_enables <= '0;
    end else if (ce && bus_req.wr) begin
      if (is_addr(bus_req, sct_pkg::ADDR_CONTROL)) begin
        mode <= bus_req.wdata[sct_pkg::CTL_MODE_LSB +: 2];
        prescale <= bus_req.wdata[sct_pkg::CTL_DIV_LSB +: 2];
      end
      if (is_addr(bus_req, sct_pkg::ADDR_IRQ_MASK)) begin
        overflow_mask <= bus_req.wdata[sct_pkg::OVF_MASK_BIT];
      end
      if (is_addr(bus_req, sct_pkg::ADDR_CLOCK_CTL)) begin
        global_tick_divider <= bus_req.wdata[sct_pkg::TICK_DIV_LSB +: 3];
      end
      if (is_addr(bus_req, sct_pkg::ADDR_RADIO_EN)) begin
        radio_irq_enables <= RADIO_W'(bus_req.wdata);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag <= 1'b0;
    end else if (wrap_ovf && !wr_low) begin
      overflow_flag <= 1'b1;
    end else if (ce && bus_req.wr && is_addr(bus_req, sct_pkg::ADDR_CONTROL)) begin
      overflow_flag <= overflow_flag & bus_req.wdata[sct_pkg::CTL_OVF_BIT];
    end
  end

  always_comb begin
    irq_any = overflow_flag & overflow_mask;
    for (int k = 0; k < NC; k++) begin
      irq_any = irq_any | (chan_flag[k] & chan_control[k].chan_irq_mask);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= irq_any;
    end
  end

  // Read data appears in the cycle after the read strobe.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= sct_pkg::BYTE_RESET;
    end else if (ce && bus_req.rd) begin
      rdata <= sct_pkg::BYTE_RESET;
      if (is_addr(bus_req, sct_pkg::ADDR_COUNT_LOW)) begin
        rdata <= count[7:0];
      end
      if (is_addr(bus_req, sct_pkg::ADDR_COUNT_HIGH)) begin
        rdata <= count_high_latch;
      end
      if (is_addr(bus_req, sct_pkg::ADDR_CONTROL)) begin
        rdata <= {chan_flag[2], chan_flag[1], chan_flag[0], overflow_flag, prescale, mode};
      end
      if (is_addr(bus_req, sct_pkg::ADDR_IRQ_MASK)) begin
        rdata <= {1'b0, overflow_mask, 6'h00};
      end
      if (is_addr(bus_req, sct_pkg::ADDR_CLOCK_CTL)) begin
        rdata <= {2'h0, global_tick_divider, 3'h0};
      end
      if (is_addr(bus_req, sct_pkg::ADDR_RADIO_EN)) begin
        rdata <= 8'(radio_irq_enables);
      end
      for (int k = 0; k < NC; k++) begin
        if (bus_req.addr == sct_pkg::ADDR_CHAN_CTL0 + 8'(k)) begin
          rdata <= chan_control[k];
        end
        if (bus_req.addr == sct_pkg::ADDR_CHAN_VAL0 + 8'(2 * k)) begin
          rdata <= chan_value[k][7:0];
        end
        if (bus_req.addr == sct_pkg::ADDR_CHAN_VAL0 + 8'(2 * k + 1)) begin
          rdata <= chan_value[k][15:8];
        end
      end
    end
  end

  AST_LOW_WRITE_CLEARS: assert property (@(posedge clock) disable iff (!rst_n)
    wr_low |=> count == sct_pkg::COUNT_RESET && dir == sct_pkg::SCT_DIR_UP)
    else $error("low byte write did not clear the counter");

  AST_HIGH_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
    rd_low |=> count_high_latch == $past(count[15:8]) && rdata == $past(count[7:0]))
    else $error("low byte read did not latch the high byte");

  AST_HALT_HOLDS: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == sct_pkg::MODE_HALT && !wr_low) |=> $stable(count))
    else $error("halted counter changed");

  AST_FREE_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
    (step && mode == sct_pkg::MODE_FREE && count == sct_pkg::COUNT_TOP && !wr_low)
    |=> count == sct_pkg::COUNT_RESET && overflow_flag)
    else $error("free-running wrap wrong");

  AST_MODULO_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
    (step && mode == sct_pkg::MODE_MODULO && count == chan_value[0] && !wr_low)
    |=> count == sct_pkg::COUNT_RESET && overflow_flag)
    else $error("modulo terminal wrong");

  AST_UPDOWN_NO_OVF: assert property (@(posedge clock) disable iff (!rst_n)
    (mode == sct_pkg::MODE_UPDOWN && !overflow_flag) |=> !overflow_flag)
    else $error("overflow set in up/down mode");

  AST_IRQ_COMBINE: assert property (@(posedge clock) disable iff (!rst_n)
    ce |=> irq == $past(irq_any))
    else $error("interrupt request does not follow flags and masks");

  AST_PRESCALE_128: assert property (@(posedge clock) disable iff (!rst_n)
    (step && prescale == sct_pkg::DIV_128 && global_tick_divider == 3'h0)
    |=> (!step || prescale != sct_pkg::DIV_128) [*8])
    else $error("prescaled tick came too soon");

endmodule

// *** verification/sct_event_src.sv ***
// Purpose: Far-side model driving the capture pins and radio events.
// Assumes: Called from the bench just after a rising clock edge.
// Notes: Pins idle low; radio sources are single-cycle pulses.
`timescale 1ns/1ps
module sct_event_src (
  input wire logic clock,
  output logic [sct_pkg::NUM_CHAN-1:0] chan_pin,
  output logic [7:0] radio_irq_event
);
  initial begin
    chan_pin = '0;
    radio_irq_event = 8'h00;
  end

  // Pulses last three clocks, so the synchroniser cannot miss them.
  task pin_pulse(input logic [sct_pkg::NUM_CHAN-1:0] sel);
    chan_pin <= sel;
    repeat (3) @(posedge clock);
    chan_pin <= '0;
    repeat (8) @(posedge clock);
  endtask

  task radio_pulse(input logic [7:0] src);
    radio_irq_event <= src;
    @(posedge clock);
    radio_irq_event <= 8'h00;
    repeat (4) @(posedge clock);
  endtask
endmodule

// *** verification/sixteen_bit_capture_timer_tb.sv ***
// Purpose: Self-checking bench of the capture timer.
// Assumes: Strobes launched right after a rising edge; no ready phase.
// Notes: Prescale count checks allow a small window for prescaler phase; mode count checks are exact.
`timescale 1ns/1ps
module sixteen_bit_capture_timer_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  sct_pkg::sct_bus_req_t bus_req = '0;
  logic [7:0] rdata;
  logic [sct_pkg::NUM_CHAN-1:0] chan_pin;
  logic [7:0] radio_irq_event;
  logic irq;
  logic [7:0] v;
  logic [15:0] cnt;
  int fail_count = 0;
  int checks_done = 0;

  always #4 clock = ~clock;

  sct_timer u_dut (.clock(clock), .resetn(resetn), .ce(ce), .bus_req(bus_req),
    .rdata(rdata), .chan_pin(chan_pin), .radio_irq_event(radio_irq_event), .irq(irq));
  sct_event_src u_src (.clock(clock), .chan_pin(chan_pin), .radio_irq_event(radio_irq_event));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req <= '0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req <= '0;
    #1 d = rdata;
    @(posedge clock);
  endtask

  task automatic rd_cnt(output logic [15:0] c);
    rd(sct_pkg::ADDR_COUNT_LOW, c[7:0]);
    rd(sct_pkg::ADDR_COUNT_HIGH, c[15:8]);
  endtask

  task automatic complete_run;
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic s_reset;
    rd_cnt(cnt);
    check(cnt, 16'h0000);
    rd(sct_pkg::ADDR_CONTROL, v);
    check({8'h00, v}, 16'h0000);
    check({15'h0000, irq}, 16'h0000);
    rd(8'h00, v);
    check({8'h00, v}, 16'h0000);
  endtask

  task automatic s_prescale;
    int w[5] = '{10, 80, 320, 1280, 160};
    logic [1:0] dc[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
    logic [7:0] tk[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08};
    for (int i = 0; i < 5; i++) begin
      wr(sct_pkg::ADDR_CLOCK_CTL, tk[i]);
      wr(sct_pkg::ADDR_COUNT_LOW, 8'h5A);
      wr(sct_pkg::ADDR_CONTROL, {4'h0, dc[i], 2'h1});
      repeat (w[i]) @(posedge clock);
      wr(sct_pkg::ADDR_CONTROL, 8'h00);
      rd_cnt(cnt);
      check({15'h0000, cnt inside {[16'h0009:16'h000D]}}, 16'h0001);
    end
    wr(sct_pkg::ADDR_CLOCK_CTL, 8'h00);
    repeat (40) @(posedge clock);
    rd_cnt(cnt);
    check({15'h0000, cnt inside {[16'h0009:16'h000D]}}, 16'h0001);
    wr(sct_pkg::ADDR_COUNT_LOW, 8'hFF);
    rd_cnt(cnt);
    check(cnt, 16'h0000);
  endtask

  task automatic s_latch;
    wr(sct_pkg::ADDR_CONTROL, 8'h01);
    repeat (100) @(posedge clock);
    rd(sct_pkg::ADDR_COUNT_LOW, v);
    repeat (300) @(posedge clock);
    rd(sct_pkg::ADDR_COUNT_HIGH, v);
    check({8'h00, v}, 16'h0000);
    wr(sct_pkg::ADDR_CONTROL, 8'h00);
  endtask

  task automatic s_free_wrap;
    wr(sct_pkg::ADDR_IRQ_MASK, 8'h40);
    wr(sct_pkg::ADDR_COUNT_LOW, 8'h00);
    wr(sct_pkg::ADDR_CONTROL, 8'h01);
    repeat (65556) @(posedge clock);
    rd(sct_pkg::ADDR_CONTROL, v);
    check({8'h00, v}, 16'h0011);
    check({15'h0000, irq}, 16'h0001);
    rd_cnt(cnt);
    check({8'h00, cnt[15:8]}, 16'h0000);
    wr(sct_pkg::ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clock);
    check({15'h0000, irq}, 16'h0000);
    wr(sct_pkg::ADDR_CONTROL, 8'h00);
  endtask

  task automatic s_modes;
    wr(sct_pkg::ADDR_CHAN_VAL0, 8'h10);
    wr(sct_pkg::ADDR_CHAN_VAL0 + 8'h01, 8'h00);
    wr(sct_pkg::ADDR_COUNT_LOW, 8'h00);
    wr(sct_pkg::ADDR_CONTROL, 8'h02);
    repeat (40) @(posedge clock);
    rd(sct_pkg::ADDR_CONTROL, v);
    check({8'h00, v}, 16'h0012);
    rd_cnt(cnt);
    check(cnt, 16'h0009);
    wr(sct_pkg::ADDR_CONTROL, 8'h00);
    wr(sct_pkg::ADDR_CHAN_VAL0, 8'h08);
    wr(sct_pkg::ADDR_COUNT_LOW, 8'h00);
    wr(sct_pkg::ADDR_CONTROL, 8'h03);
    repeat (41) @(posedge clock);
    rd(sct_pkg::ADDR_CONTROL, v);
    check({8'h00, v}, 16'h0003);
    rd_cnt(cnt);
    check(cnt, 16'h0004);
    wr(sct_pkg::ADDR_CONTROL, 8'h00);
  endtask

  task automatic s_capture;
    wr(sct_pkg::ADDR_CHAN_CTL0, 8'h02);
    wr(sct_pkg::ADDR_CHAN_CTL0 + 8'h01, 8'h41);
    wr(sct_pkg::ADDR_CHAN_CTL0 + 8'h02, 8'h00);
    wr(sct_pkg::ADDR_COUNT_LOW, 8'h00);
    wr(sct_pkg::ADDR_CONTROL, 8'h01);
    repeat (20) @(posedge clock);
    u_src.pin_pulse(3'h2);
    rd(sct_pkg::ADDR_CONTROL, v);
    check({8'h00, v}, 16'h0041);
    check({15'h0000, irq}, 16'h0001);
    rd(sct_pkg::ADDR_CHAN_VAL0 + 8'h03, cnt[15:8]);
    rd(sct_pkg::ADDR_CHAN_VAL0 + 8'h02, cnt[7:0]);
    check({15'h0000, cnt inside {[16'h0014:16'h0030]}}, 16'h0001);
    u_src.pin_pulse(3'h5);
    rd(sct_pkg::ADDR_CONTROL, v);
    check({8'h00, v}, 16'h0061);
    wr(sct_pkg::ADDR_CONTROL, 8'hF1);
    rd(sct_pkg::ADDR_CONTROL, v);
    check({8'h00, v}, 16'h0061);
    wr(sct_pkg::ADDR_CONTROL, 8'hB1);
    rd(sct_pkg::ADDR_CONTROL, v);
    check({8'h00, v}, 16'h0021);
    check({15'h0000, irq}, 16'h0000);
    wr(sct_pkg::ADDR_RADIO_EN, 8'h04);
    wr(sct_pkg::ADDR_CHAN_CTL0 + 8'h02, 8'h81);
    u_src.radio_pulse(8'h01);
    rd(sct_pkg::ADDR_CONTROL, v);
    check({8'h00, v}, 16'h0021);
    u_src.radio_pulse(8'h04);
    rd(sct_pkg::ADDR_CONTROL, v);
    check({8'h00, v}, 16'h00A1);
    wr(sct_pkg::ADDR_CONTROL, 8'h00);
  endtask

  initial begin
    #760000;
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    s_reset();
    s_prescale();
    s_latch();
    s_free_wrap();
    s_modes();
    s_capture();
    complete_run();
  end
endmodule
